// ---- ccs_defs.svh ----
// offsets, field positions, reset values and counts of the converter control block
// assumes inclusion by bare name from every file that needs them
`ifndef CCS_DEFS_SVH
`define CCS_DEFS_SVH

// ****************************************
// register byte offsets on the apb bus
// ****************************************
`define CCS_OFF_STATUS_CTRL 8'h00
`define CCS_OFF_RESULT_HIGH 8'h04
`define CCS_OFF_RESULT_LOW 8'h08
`define CCS_OFF_CLOCK_CFG 8'h0C

// ****************************************
// status/control fields
// ****************************************
`define CCS_SC_DONE_BIT 7
`define CCS_SC_IRQ_EN_BIT 6
`define CCS_SC_CONT_BIT 5
`define CCS_SC_CHAN_MSB 4
`define CCS_CHAN_OFF 5'h1F
`define CCS_SC_RESET 8'h1F

// ****************************************
// clock configuration fields
// ****************************************
`define CCS_CK_LOW_POWER_BIT 7
`define CCS_CK_DIV_MSB 6
`define CCS_CK_DIV_LSB 5
`define CCS_CK_BUS_SRC_BIT 4
`define CCS_CK_MODE_MSB 3
`define CCS_CK_MODE_LSB 2
`define CCS_CK_LONG_SAMPLE_BIT 1
`define CCS_CK_ASYNC_EN_BIT 0
`define CCS_CK_RESET 8'h00
`define CCS_MODE_TEN_BIT 2'h1
`define CCS_MODE_TEN_BIT_HW 2'h3

// ****************************************
// channel codes
// ****************************************
`define CCS_CHAN_LAST_PIN 5'h07
`define CCS_CHAN_PIN8 5'h18
`define CCS_CHAN_PIN9 5'h19
`define CCS_CHAN_BANDGAP 5'h1A
`define CCS_CHAN_REF_HIGH 5'h1D
`define CCS_CHAN_REF_LOW 5'h1E

// ****************************************
// timing, in converter clock cycles
// ****************************************
`define CCS_SAMPLE_SHORT_CYC 5'h04
`define CCS_SAMPLE_LONG_CYC 5'h18
`define CCS_RES_BITS 10

`endif

// ---- ccs_pkg.sv ----
// types shared by the converter control block
// assumes ccs_defs.svh is on the include path
`default_nettype none
`include "ccs_defs.svh"

package ccs_pkg;

  typedef enum logic [1:0] {
    CCS_SAR_IDLE,
    CCS_SAR_SAMPLE,
    CCS_SAR_STEP
  } ccs_sar_st_t;

  typedef struct packed {
    ccs_sar_st_t st;
    logic [4:0] cnt;
    logic [3:0] bit_idx;
    logic [9:0] code;
    logic [9:0] result;
    logic done;
  } ccs_sar_state_t;

  typedef struct packed {
    logic done;
    logic irq_en;
    logic cont;
    logic [4:0] chan;
    logic [7:0] clk_cfg;
    logic [1:0] res_hi;
    logic [7:0] res_lo;
    logic lock;
    logic run;
    logic stop_d;
    logic [2:0] div_cnt;
  } ccs_ctl_state_t;

endpackage : ccs_pkg

`default_nettype wire

// ---- ccs_conv_if.sv ----
// carrier between the control logic and the approximation sequencer
// assumes one clock domain shared by both ends
`timescale 1ns/1ns
`default_nettype none

interface ccs_conv_if;
  logic tick;
  logic start;
  logic abort;
  logic long_sample;
  logic busy;
  logic done;
  logic [9:0] result;

  modport ctl (output tick, output start, output abort, output long_sample,
               input busy, input done, input result);
  modport sar (input tick, input start, input abort, input long_sample,
               output busy, output done, output result);
endinterface : ccs_conv_if

`default_nettype wire

// ---- ccs_sar.sv ----
// successive approximation sequencer: sample phase, then ten trial steps
// assumes an analog comparator answering within one converter clock tick
`timescale 1ns/1ns
`default_nettype none
`include "ccs_defs.svh"

module ccs_sar (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // control side
  ccs_conv_if.sar cv,
  // analog side
  input wire logic cmp_in,
  output logic sample_en,
  output logic [9:0] dac_code
);
  import ccs_pkg::*;

  ccs_sar_state_t q_ff;
  ccs_sar_state_t nxt_q;

  // ****************************************
  // sequencing
  // ****************************************
  always_comb begin
    nxt_q = q_ff;
    nxt_q.done = 1'b0;
    case (q_ff.st)
      CCS_SAR_IDLE: begin
      end
      CCS_SAR_SAMPLE: begin
        if (cv.tick) begin
          if (q_ff.cnt == 5'h00) begin
            nxt_q.st = CCS_SAR_STEP;
            nxt_q.bit_idx = 4'h9;
            nxt_q.code = 10'h200;
          end else begin
            nxt_q.cnt = q_ff.cnt - 5'h01;
          end
        end
      end
      CCS_SAR_STEP: begin
        if (cv.tick) begin
          // comparator high keeps the trial bit
          nxt_q.code[q_ff.bit_idx] = cmp_in;
          if (q_ff.bit_idx == 4'h0) begin
            nxt_q.result = {q_ff.code[9:1], cmp_in};
            nxt_q.done = 1'b1;
            nxt_q.st = CCS_SAR_IDLE; // R16
          end else begin
            nxt_q.bit_idx = q_ff.bit_idx - 4'h1;
            nxt_q.code[q_ff.bit_idx - 4'h1] = 1'b1;
          end
        end
      end
      default: begin
        nxt_q.st = CCS_SAR_IDLE;
      end
    endcase
    if (cv.abort) begin
      nxt_q.st = CCS_SAR_IDLE; // R5
      nxt_q.done = 1'b0;
    end
    // a start in the abort cycle restarts cleanly
    if (cv.start) begin
      nxt_q.st = CCS_SAR_SAMPLE;
      nxt_q.cnt = cv.long_sample ? (`CCS_SAMPLE_LONG_CYC - 5'h01)
                                 : (`CCS_SAMPLE_SHORT_CYC - 5'h01);
      nxt_q.code = 10'h000;
      nxt_q.done = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q_ff <= '{st: CCS_SAR_IDLE, cnt: 5'h00, bit_idx: 4'h0, code: 10'h000,
                result: 10'h000, done: 1'b0};
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign cv.busy = (q_ff.st != CCS_SAR_IDLE);
  assign cv.done = q_ff.done;
  assign cv.result = q_ff.result;
  assign sample_en = (q_ff.st == CCS_SAR_SAMPLE);
  assign dac_code = q_ff.code;

endmodule : ccs_sar

`default_nettype wire

// ---- ccs_top.sv ----
// control and status logic of a 10-bit approximation converter behind apb
// assumes the debug break and stop indications are synchronous to sys_clk
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "ccs_defs.svh"

// Operation
// R1: with break clearing enabled, flags cleared during break stay cleared afterwards
// R2: with break clearing disabled, break accesses leave converter status flags unchanged
// R3: a two-step clear started before break holds during break, completes after
// R4: no hardware trigger; conversions start only from status/control writes
// R5: status/control write aborts conversion; starts new unless channel all ones
// R6: done flag read-only, set per conversion, cleared by write or low read
// R7: interrupt at conversion end when enabled; dropped by result read or write
// R8: continuous bit with live channel converts back to back, updating results
// R9: continuous stops on reset, clock write, control write, or plain stop entry
// R10: write with continuous set and live channel aborts and starts continuous
// R11: system keeps bus clock fast enough for exact continuous sample timing
// R12: continuous clear gives exactly one conversion per live-channel write
// R13: five-bit channel map: pins 0-7, 8, 9, bandgap, references high/low
// R14: all-ones channel powers converter off and isolates the pad
// R15: all-ones write during continuous ends it with no extra conversion
// R16: converter drops to low power automatically after each conversion
// R17: unused or reserved channel codes give an undefined result
// R18: software converts bandgap only while the voltage monitor is powered
// R19: plain stop entry aborts conversion; results keep last completed value
// R20: in ten-bit mode a high read blocks transfers until the low read
// R21: interrupt equals done flag and enable; flag sets regardless of enable
module ccs_top #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // system state
  input wire logic break_state,
  input wire logic break_clear_enable,
  input wire logic stop_mode,
  // analog front end
  input wire logic cmp_in,
  output logic sample_en,
  output logic [9:0] dac_code,
  output logic [4:0] channel_select,
  output logic pad_connect,
  output logic converter_power,
  output logic low_power_cfg,
  output logic clock_source_bus,
  // interrupt request
  output logic conv_irq
);
  import ccs_pkg::*;

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] off);
    // size the offset to the bus width: upper bits zero when wider than 8, truncated when narrower
    reg_hit = (addr == ADDR_W'(off));
  endfunction : reg_hit

  // channels wired to a pad, as opposed to internal references
  function automatic logic chan_is_pin(input logic [4:0] ch);
    chan_is_pin = (ch <= `CCS_CHAN_LAST_PIN) || (ch == `CCS_CHAN_PIN8)
                  || (ch == `CCS_CHAN_PIN9);
  endfunction : chan_is_pin

  // codes with a defined input behind them
  function automatic logic chan_is_defined(input logic [4:0] ch);
    chan_is_defined = chan_is_pin(ch) || (ch == `CCS_CHAN_BANDGAP)
                      || (ch == `CCS_CHAN_REF_HIGH) || (ch == `CCS_CHAN_REF_LOW); // R13
  endfunction : chan_is_defined

  ccs_ctl_state_t q_ff;
  ccs_ctl_state_t nxt_q;
  ccs_conv_if cv ();

  // ****************************************
  // bus decode
  // ****************************************
  logic acc;
  logic wr;
  logic rd;
  logic hit_sc;
  logic hit_hi;
  logic hit_lo;
  logic hit_ck;
  logic mapped;
  logic sc_wr;
  logic ck_wr;
  logic hi_rd;
  logic lo_rd;
  logic protect;
  logic ten_bit;
  logic async_en;
  logic stop_abort;
  logic new_start;
  logic cont_next;
  logic [2:0] div_last;
  logic [7:0] rounded;

  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign hit_sc = reg_hit(paddr, `CCS_OFF_STATUS_CTRL);
  assign hit_hi = reg_hit(paddr, `CCS_OFF_RESULT_HIGH);
  assign hit_lo = reg_hit(paddr, `CCS_OFF_RESULT_LOW);
  assign hit_ck = reg_hit(paddr, `CCS_OFF_CLOCK_CFG);
  assign mapped = hit_sc || hit_hi || hit_lo || hit_ck;
  // only lane 0 carries register bits
  assign sc_wr = wr && hit_sc && pstrb[0];
  assign ck_wr = wr && hit_ck && pstrb[0];
  assign hi_rd = rd && hit_hi;
  assign lo_rd = rd && hit_lo;

  // ****************************************
  // mode decode
  // ****************************************
  // break with clearing disabled blocks clears of status flags by access
  assign protect = break_state && !break_clear_enable; // R2
  assign ten_bit = (q_ff.clk_cfg[`CCS_CK_MODE_MSB:`CCS_CK_MODE_LSB] == `CCS_MODE_TEN_BIT)
                   || (q_ff.clk_cfg[`CCS_CK_MODE_MSB:`CCS_CK_MODE_LSB]
                       == `CCS_MODE_TEN_BIT_HW);
  assign async_en = q_ff.clk_cfg[`CCS_CK_ASYNC_EN_BIT];
  assign stop_abort = stop_mode && !q_ff.stop_d && !async_en; // R19
  // hardware-trigger mode has no trigger source, so software starts only
  assign new_start = sc_wr && (pwdata[4:0] != `CCS_CHAN_OFF); // R4 R5 R14
  // restart after each completion while continuous runs
  assign cont_next = cv.done && q_ff.run && !(stop_mode && !async_en) && !sc_wr; // R8

  // ****************************************
  // converter clock divider
  // ****************************************
  assign div_last = 3'((4'h1 << q_ff.clk_cfg[`CCS_CK_DIV_MSB:`CCS_CK_DIV_LSB]) - 4'h1);
  assign cv.tick = (q_ff.div_cnt >= div_last);

  // 8-bit mode rounds the 10-bit code, saturating at full scale
  assign rounded = (cv.result[9:2] == 8'hFF) ? 8'hFF
                   : 8'(cv.result[9:2] + {7'h00, cv.result[1]});

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    nxt_q = q_ff;
    nxt_q.stop_d = stop_mode;
    nxt_q.div_cnt = cv.tick ? 3'h0 : (q_ff.div_cnt + 3'h1);

    if (ck_wr) begin
      nxt_q.clk_cfg = pwdata[7:0];
      nxt_q.run = 1'b0; // R9
    end

    if (sc_wr) begin
      nxt_q.irq_en = pwdata[`CCS_SC_IRQ_EN_BIT];
      nxt_q.cont = pwdata[`CCS_SC_CONT_BIT];
      nxt_q.chan = pwdata[`CCS_SC_CHAN_MSB:0];
      // all-ones ends continuous with no extra conversion
      nxt_q.run = pwdata[`CCS_SC_CONT_BIT] && new_start; // R9 R10 R12 R15
    end

    if (stop_abort) begin
      nxt_q.run = 1'b0; // R9 R19
    end

    // clear by write or low read, unless break protection holds it
    if ((sc_wr || lo_rd) && !protect) begin
      nxt_q.done = 1'b0; // R1 R6 R7
    end
    if (cv.done) begin
      nxt_q.done = 1'b1; // R6 R21
    end

    // second step of the interlock; a high read before break keeps it
    if (lo_rd && !protect) begin
      nxt_q.lock = 1'b0; // R3 R20
    end
    if (hi_rd && ten_bit) begin
      nxt_q.lock = 1'b1; // R20
    end

    // a locked pair drops the new result, as intended
    if (cv.done && !(q_ff.lock && ten_bit)) begin
      if (ten_bit) begin
        nxt_q.res_hi = cv.result[9:8]; // R8
        nxt_q.res_lo = cv.result[7:0];
      end else begin
        nxt_q.res_hi = 2'h0;
        nxt_q.res_lo = rounded;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q_ff <= '{done: 1'b0, irq_en: 1'b0, cont: 1'b0, chan: `CCS_CHAN_OFF,
                clk_cfg: `CCS_CK_RESET, res_hi: 2'h0, res_lo: 8'h00, lock: 1'b0,
                run: 1'b0, stop_d: 1'b0, div_cnt: 3'h0}; // R9
    end else begin
      q_ff <= nxt_q;
    end
  end

  // ****************************************
  // sequencer control
  // ****************************************
  assign cv.start = new_start || cont_next; // R5 R8 R12
  assign cv.abort = sc_wr || stop_abort; // R5 R10 R19
  assign cv.long_sample = q_ff.clk_cfg[`CCS_CK_LONG_SAMPLE_BIT];

  ccs_sar u_sar (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .cv(cv),
    .cmp_in(cmp_in),
    .sample_en(sample_en),
    .dac_code(dac_code)
  );

  // ****************************************
  // apb read data and answer
  // ****************************************
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd) begin
      if (hit_sc) begin
        prdata[7:0] = {q_ff.done, q_ff.irq_en, q_ff.cont, q_ff.chan};
      end else if (hit_hi) begin
        prdata[1:0] = q_ff.res_hi;
      end else if (hit_lo) begin
        prdata[7:0] = q_ff.res_lo;
      end else if (hit_ck) begin
        prdata[7:0] = q_ff.clk_cfg;
      end
    end
  end

  // zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;

  // ****************************************
  // analog and interrupt outputs
  // ****************************************
  // unused and reserved codes still convert; the result is just meaningless
  assign channel_select = q_ff.chan; // R17
  // pad isolated whenever off or converting an internal node
  assign pad_connect = cv.busy && chan_is_pin(q_ff.chan)
                       && (q_ff.chan != `CCS_CHAN_OFF); // R14
  // powered only while a conversion runs
  assign converter_power = cv.busy && chan_is_defined(q_ff.chan) || cv.busy
                           && (q_ff.chan != `CCS_CHAN_OFF); // R14 R16
  assign low_power_cfg = q_ff.clk_cfg[`CCS_CK_LOW_POWER_BIT];
  assign clock_source_bus = q_ff.clk_cfg[`CCS_CK_BUS_SRC_BIT];
  assign conv_irq = q_ff.done && q_ff.irq_en; // R7 R21

endmodule : ccs_top

`default_nettype wire

// ---- ccs_asserts.sv ----
// port checker of the converter control block
// assumes it is bound into ccs_top
`timescale 1ns/1ns
`default_nettype none
`include "ccs_defs.svh"
module ccs_asserts #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  // system and front end
  input wire logic break_state,
  input wire logic break_clear_enable,
  input wire logic sample_en,
  input wire logic [4:0] channel_select,
  input wire logic pad_connect,
  input wire logic converter_power,
  input wire logic conv_irq
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  logic ctl_wr;
  logic clr_ok;
  assign ctl_wr = psel && penable && pwrite && pstrb[0] && paddr == `CCS_OFF_STATUS_CTRL;
  assign clr_ok = !break_state || break_clear_enable;
  // ****************************************
  // properties
  // ****************************************
  sequence s_low_rd;
    psel && penable && !pwrite && paddr == `CCS_OFF_RESULT_LOW;
  endsequence
  sequence s_running;
    converter_power ##1 converter_power;
  endsequence
  property p_off_dark;
    channel_select == `CCS_CHAN_OFF |-> !converter_power && !pad_connect;
  endproperty
  property p_pad_map;
    pad_connect |-> channel_select <= `CCS_CHAN_LAST_PIN ||
      channel_select inside {`CCS_CHAN_PIN8, `CCS_CHAN_PIN9};
  endproperty
  property p_sample_pow;
    sample_en |-> converter_power;
  endproperty
  property p_start;
    ctl_wr && pwdata[4:0] != `CCS_CHAN_OFF |-> ##[1:2] s_running;
  endproperty
  property p_halt;
    ctl_wr && pwdata[4:0] == `CCS_CHAN_OFF |=> (!converter_power)[*2];
  endproperty
  // completion pulses in the cycle power drops; two idle cycles rule it out
  property p_wr_clear;
    ctl_wr && clr_ok && !converter_power && !$past(converter_power) |=> !conv_irq;
  endproperty
  property p_rd_clear;
    s_low_rd ##0 (clr_ok && !converter_power && !$past(converter_power)) |=> !conv_irq;
  endproperty
  property p_break_hold;
    break_state && !break_clear_enable && conv_irq && !ctl_wr |=> conv_irq;
  endproperty
  a_off_dark: assert property (p_off_dark)
    else $error("converter live with channel off");
  a_pad_map: assert property (p_pad_map)
    else $error("pad connected for a non-pad channel");
  a_sample_pow: assert property (p_sample_pow)
    else $error("sampling while unpowered");
  a_start: assert property (p_start)
    else $error("no conversion after control write");
  a_halt: assert property (p_halt)
    else $error("conversion after channel-off write");
  a_wr_clear: assert property (p_wr_clear)
    else $error("control write left interrupt up");
  a_rd_clear: assert property (p_rd_clear)
    else $error("low read left interrupt up");
  a_break_hold: assert property (p_break_hold)
    else $error("flag changed during protected break");
endmodule : ccs_asserts

bind ccs_top ccs_asserts #(.ADDR_W(ADDR_W)) u_asserts (
  .sys_clk(sys_clk),
  .sys_rst(sys_rst),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .pstrb(pstrb),
  .break_state(break_state),
  .break_clear_enable(break_clear_enable),
  .sample_en(sample_en),
  .channel_select(channel_select),
  .pad_connect(pad_connect),
  .converter_power(converter_power),
  .conv_irq(conv_irq)
);
`default_nettype wire

// ---- ccs_top_tb.sv ----
// self-checking bench of the converter control block
// assumes ccs_top and its checker are compiled first
`timescale 1ns/1ns
`default_nettype none
`include "ccs_defs.svh"
module ccs_top_tb;
  logic sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
  logic break_state, break_clear_enable, stop_mode, sample_en, pad_connect;
  logic converter_power, conv_irq, low_power_cfg, clock_source_bus;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] pstrb;
  logic [9:0] dac_code;
  logic [4:0] channel_select;
  int failures, tests_run, seed, vin, old;
  // analog input model: comparator against the trial code
  wire cmp_in = vin >= int'(dac_code);
  ccs_top u_dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .break_state(break_state),
    .break_clear_enable(break_clear_enable), .stop_mode(stop_mode),
    .cmp_in(cmp_in), .sample_en(sample_en), .dac_code(dac_code),
    .channel_select(channel_select), .pad_connect(pad_connect),
    .converter_power(converter_power), .low_power_cfg(low_power_cfg),
    .clock_source_bus(clock_source_bus), .conv_irq(conv_irq)
  );
  // ****************************************
  // tasks
  // ****************************************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= wr ? 4'hF : 4'h0;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    // answer and data are taken at the edge that sees pready high
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    err = pslverr;
    if (pready !== 1'b1) failures++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : bus
  task idle(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : idle
  // bounded wait; a missing completion counts as a mismatch
  task wait_irq;
    int n;
    n = 0;
    while (conv_irq !== 1'b1 && n < 500) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 500) failures++;
  endtask : wait_irq
  task report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    report_and_stop;
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    seed = 32'hBF89;
    {sys_rst, psel, penable, pwrite, break_state, break_clear_enable} = 6'h20;
    {stop_mode, paddr, pwdata, pstrb, vin} = '0;
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    bus(0, `CCS_OFF_STATUS_CTRL, 0);
    chk(q, {24'h0, `CCS_SC_RESET});
    bus(0, `CCS_OFF_CLOCK_CFG, 0);
    chk(q, {24'h0, `CCS_CK_RESET});
    bus(0, `CCS_OFF_RESULT_LOW, 0);
    chk(q, 0);
    bus(0, 8'h10, 0);
    chk({31'h0, err}, 1);
    bus(1, `CCS_OFF_CLOCK_CFG, {28'h0, `CCS_MODE_TEN_BIT, 2'h0});
    for (int c = 0; c < 31; c++) begin
      vin <= $random(seed) & 32'h3FF;
      bus(1, `CCS_OFF_STATUS_CTRL, 32'h40 | c);
      idle(1);
      chk(pad_connect, c < 8 || c == 24 || c == 25);
      wait_irq;
      bus(0, `CCS_OFF_RESULT_HIGH, 0);
      if (c < 8 || c inside {24, 25, 26, 29, 30}) chk(q, vin >> 8);
      bus(0, `CCS_OFF_RESULT_LOW, 0);
      if (c < 8 || c inside {24, 25, 26, 29, 30}) chk(q, vin & 255);
      bus(0, `CCS_OFF_STATUS_CTRL, 0);
      chk(q, 32'h40 | c);
      idle(40);
      chk(converter_power, 0);
      chk(conv_irq, 0);
    end
    vin <= $random(seed) & 32'h3FF;
    bus(1, `CCS_OFF_STATUS_CTRL, 32'h63);
    wait_irq;
    bus(0, `CCS_OFF_RESULT_HIGH, 0);
    chk(q, vin >> 8);
    old = vin;
    vin <= $random(seed) & 32'h3FF;
    idle(40);
    bus(0, `CCS_OFF_RESULT_LOW, 0);
    chk(q, old & 255);
    idle(40);
    bus(0, `CCS_OFF_RESULT_HIGH, 0);
    chk(q, vin >> 8);
    bus(0, `CCS_OFF_RESULT_LOW, 0);
    chk(q, vin & 255);
    @(posedge sys_clk);
    stop_mode <= 1'b1;
    idle(5);
    chk(converter_power, 0);
    @(posedge sys_clk);
    stop_mode <= 1'b0;
    idle(40);
    chk(converter_power, 0);
    bus(0, `CCS_OFF_RESULT_LOW, 0);
    chk(q, vin & 255);
    // continuous ended by a channel-off write, then by a clock write
    for (int k = 0; k < 2; k++) begin
      bus(1, `CCS_OFF_STATUS_CTRL, 32'h63);
      idle(20);
      bus(1, k ? `CCS_OFF_CLOCK_CFG : `CCS_OFF_STATUS_CTRL, k ? 32'h04 : 32'h7F);
      idle(40);
      bus(0, `CCS_OFF_RESULT_LOW, 0);
      idle(40);
      chk(conv_irq, 0);
      chk(converter_power, 0);
    end
    bus(1, `CCS_OFF_STATUS_CTRL, 32'h45);
    wait_irq;
    @(posedge sys_clk);
    break_state <= 1'b1;
    bus(0, `CCS_OFF_RESULT_LOW, 0);
    bus(0, `CCS_OFF_STATUS_CTRL, 0);
    chk(q, 32'hC5);
    idle(0);
    chk(conv_irq, 1);
    @(posedge sys_clk);
    break_state <= 1'b0;
    bus(0, `CCS_OFF_RESULT_LOW, 0);
    idle(0);
    chk(conv_irq, 0);
    bus(1, `CCS_OFF_STATUS_CTRL, 32'h45);
    wait_irq;
    @(posedge sys_clk);
    break_state <= 1'b1;
    break_clear_enable <= 1'b1;
    bus(1, `CCS_OFF_STATUS_CTRL, 32'h5F);
    @(posedge sys_clk);
    break_state <= 1'b0;
    break_clear_enable <= 1'b0;
    bus(0, `CCS_OFF_STATUS_CTRL, 0);
    chk(q, 32'h5F);
    // 8-bit mode, divide by 8, long sample: slow, rounded, no interlock
    bus(1, `CCS_OFF_CLOCK_CFG, 32'hF2);
    bus(0, `CCS_OFF_CLOCK_CFG, 0);
    chk(q, 32'hF2);
    chk({low_power_cfg, clock_source_bus}, 2'h3);
    vin <= $random(seed) & 32'h3FF;
    bus(1, `CCS_OFF_STATUS_CTRL, 32'h42);
    idle(1);
    chk(channel_select, 5'h02);
    idle(100);
    chk(converter_power, 1);
    wait_irq;
    bus(0, `CCS_OFF_RESULT_HIGH, 0);
    chk(q, 0);
    old = (vin >> 2) + ((vin >> 1) & 1);
    bus(0, `CCS_OFF_RESULT_LOW, 0);
    chk(q, (old > 255) ? 255 : old);
    idle(0);
    chk(conv_irq, 0);
    report_and_stop;
  end
endmodule : ccs_top_tb
`default_nettype wire
